/* design/dcr_regs.sv */
/*
 * CPU data register file: accumulators, transition, temporary and pointer
 * registers, with memory-mapped access and instruction-unit ports.
 * Assumes the decoder, ALUs, MACs and address generator drive the request
 * ports synchronously to CLK; RST is synchronous and active high.
 */
`timescale 1ns/1ps
`default_nettype none
module dcr_regs
	import dcr_pkg::*;
(
	input  wire logic                       CLK,
	input  wire logic                       RST,
	input  wire logic                       LEGACY_COMPAT_FLAG,
	input  wire logic [ASM_W-1:0]           SHIFT_MODE_FIELD,
	input  wire dcr_mmr_req_t               MMR_REQ,
	output logic [WORD_W-1:0]               MMR_RDATA,
	output logic                            MMR_HIT,
	input  wire logic                       ACC_WE,
	input  wire logic [1:0]                 ACC_SEL,
	input  wire dcr_acc_t                   ACC_WDATA,
	input  wire logic                       SWAP_REQ,
	input  wire logic [1:0]                 SWAP_A,
	input  wire logic [1:0]                 SWAP_B,
	output logic                            SWAP_INVALID,
	input  wire dcr_ext_req_t               EXT_REQ,
	input  wire logic                       TMP_WE,
	input  wire logic [1:0]                 TMP_SEL,
	input  wire logic [WORD_W-1:0]          TMP_WDATA,
	input  wire logic [1:0]                 MUL_TSEL,
	input  wire logic [1:0]                 SHIFT_TSEL,
	input  wire logic [1:0]                 METRIC_TSEL,
	output logic [WORD_W-1:0]               MUL_OPERAND,
	output logic [WORD_W-1:0]               SHIFT_COUNT,
	output logic [WORD_W-1:0]               VITERBI_METRIC,
	input  wire logic                       XPTR_WE,
	input  wire logic [3:0]                 XPTR_SEL,
	input  wire dcr_xptr_t                  XPTR_WDATA,
	input  wire logic                       ALU_AR_WE,
	input  wire logic [2:0]                 ALU_AR_SEL,
	input  wire logic [WORD_W-1:0]          ALU_AR_WDATA,
	input  wire dcr_agen_req_t [1:0]        AGEN_REQ,
	output logic [1:0][PTR_W-1:0]           DATA_ADDR,
	output logic [PTR_W-1:0]                COEF_ADDR,
	output dcr_acc_t [N_ACC-1:0]            ACC_OUT,
	output logic [1:0][WORD_W-1:0]          TRN_OUT,
	output dcr_xptr_t [N_PTR-1:0]           PTR_OUT
);
	dcr_acc_t  [N_ACC-1:0]        acc_reg;
	logic      [1:0][WORD_W-1:0]  trn_reg;
	logic      [N_TMP-1:0][WORD_W-1:0] tmp_reg;
	dcr_xptr_t [N_PTR-1:0]        ptr_reg;
	dcr_xptr_t [1:0]              step_next;
	logic      [1:0]              acc_dst;
	logic                         swap_ok;
	logic                         dec_high;
	logic                         dec_low;
	logic                         dec_full;
	logic      [WORD_W-1:0]       asm_view;
	logic      [WORD_W-1:0]       rd_next;
	logic                         hit_next;

	// Maps a decoder accumulator code; legacy A/B land on 0/1.
	function automatic logic [1:0] acc_map(input logic [1:0] sel, input logic legacy);
		acc_map = legacy ? {1'b0, sel[0]} : sel;
	endfunction

	// True for a mapped write to the given word address.
	function automatic logic mmr_wr(input dcr_mmr_req_t req, input logic [MA_W-1:0] a);
		mmr_wr = req.we && (req.addr == a);
	endfunction

	// Temp register as seen by users; temp 2 follows shift mode in legacy.
	function automatic logic [WORD_W-1:0] tmp_view(input logic [1:0] sel,
		input logic legacy, input logic [WORD_W-1:0] t_asm,
		input logic [N_TMP-1:0][WORD_W-1:0] t);
		tmp_view = (legacy && sel == TMP_ASM_IX) ? t_asm : t[sel];
	endfunction

	// Unit-write accumulator codes pass through the legacy mapping; swap codes do not.
	always_comb
	begin
		acc_dst = acc_map(ACC_SEL, LEGACY_COMPAT_FLAG);
		// Pairs must differ in bit 1 and agree in bit 0: 0-2 or 1-3.
		swap_ok = (SWAP_A[0] == SWAP_B[0]) && (SWAP_A[1] != SWAP_B[1]);
		asm_view = WORD_W'($signed(SHIFT_MODE_FIELD));
	end

	dcr_extremum u_extremum
	(
		.a        (acc_reg[EXT_REQ.src_a]),
		.b        (acc_reg[EXT_REQ.src_b]),
		.is_max   (EXT_REQ.is_max),
		.dec_high (dec_high),
		.dec_low  (dec_low),
		.dec_full (dec_full)
	);

	// Two address-generator lanes serve single and dual indirect modes.
	for (genvar l = 0; l < 2; l++)
	begin : g_lane
		dcr_addr_step u_step
		(
			.ptr    (ptr_reg[AGEN_REQ[l].sel]),
			.step   (AGEN_REQ[l].step),
			.wrap16 (AGEN_REQ[l].wrap16),
			.next   (step_next[l])
		);
	end

	// Accumulators: mapped part writes, then swap, then unit write.
	for (genvar g = 0; g < N_ACC; g++)
	begin : g_acc
		always_ff @(posedge CLK)
		begin
			if (RST)
				acc_reg[g] <= '0;
			else
			begin
				if (mmr_wr(MMR_REQ, MA_ACC_LOW[g]))
					acc_reg[g].low <= MMR_REQ.wdata;
				if (mmr_wr(MMR_REQ, MA_ACC_HIGH[g]))
					acc_reg[g].high <= MMR_REQ.wdata;
				if (mmr_wr(MMR_REQ, MA_ACC_GUARD[g]))
					acc_reg[g].guard <= MMR_REQ.wdata[GUARD_W-1:0];
				if (SWAP_REQ && swap_ok && SWAP_A == 2'(g))
					acc_reg[g] <= acc_reg[SWAP_B];
				if (SWAP_REQ && swap_ok && SWAP_B == 2'(g))
					acc_reg[g] <= acc_reg[SWAP_A];
				if (ACC_WE && acc_dst == 2'(g))
					acc_reg[g] <= ACC_WDATA;
			end
		end
	end

	// Flags a refused swap pairing for one cycle.
	always_ff @(posedge CLK)
	begin
		if (RST)
			SWAP_INVALID <= 1'b0;
		else
			SWAP_INVALID <= SWAP_REQ && !swap_ok;
	end

	// Transition registers shift in one decision bit per selection.
	always_ff @(posedge CLK)
	begin
		if (RST)
			trn_reg <= '0;
		else
		begin
			if (mmr_wr(MMR_REQ, MA_TRANSITION_REG_0))
				trn_reg[0] <= MMR_REQ.wdata;
			if (mmr_wr(MMR_REQ, MA_TRANSITION_REG_1))
				trn_reg[1] <= MMR_REQ.wdata;
			unique case (EXT_REQ.op)
				EXT_DUAL16:
				begin
					trn_reg[0] <= {trn_reg[0][WORD_W-2:0], dec_high};
					trn_reg[1] <= {trn_reg[1][WORD_W-2:0], dec_low};
				end
				EXT_SINGLE:
					trn_reg[EXT_REQ.trn_sel] <=
						{trn_reg[EXT_REQ.trn_sel][WORD_W-2:0], dec_full};
				EXT_NONE:
					;
				default:
					;
			endcase
		end
	end

	// Temporary registers; temp 2 is frozen while legacy mode holds it.
	for (genvar t = 0; t < N_TMP; t++)
	begin : g_tmp
		always_ff @(posedge CLK)
		begin
			if (RST)
				tmp_reg[t] <= WORD_RST;
			else if (!(LEGACY_COMPAT_FLAG && 2'(t) == TMP_ASM_IX))
			begin
				if (mmr_wr(MMR_REQ, MA_TMP[t]))
					tmp_reg[t] <= MMR_REQ.wdata;
				if (TMP_WE && TMP_SEL == 2'(t))
					tmp_reg[t] <= TMP_WDATA;
			end
		end
	end

	// Temp operands handed to the multiplier, shifter and Viterbi ALU.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			MUL_OPERAND    <= WORD_RST;
			SHIFT_COUNT    <= WORD_RST;
			VITERBI_METRIC <= WORD_RST;
		end
		else
		begin
			MUL_OPERAND    <= tmp_view(MUL_TSEL, LEGACY_COMPAT_FLAG, asm_view, tmp_reg);
			SHIFT_COUNT    <= tmp_view(SHIFT_TSEL, LEGACY_COMPAT_FLAG, asm_view, tmp_reg);
			VITERBI_METRIC <= tmp_view(METRIC_TSEL, LEGACY_COMPAT_FLAG, asm_view, tmp_reg);
		end
	end

	// Pointers: mapped low word, full writes, stepping, then ALU low word.
	for (genvar p = 0; p < N_PTR; p++)
	begin : g_ptr
		always_ff @(posedge CLK)
		begin
			if (RST)
				ptr_reg[p] <= '0;
			else
			begin
				if (mmr_wr(MMR_REQ, MA_PTR_LOW[p]))
					ptr_reg[p].low <= MMR_REQ.wdata;
				if (p == COEF_IX && mmr_wr(MMR_REQ, MA_COEF_POINTER_PAGE))
					ptr_reg[p].page <= MMR_REQ.wdata[PAGE_W-1:0];
				if (XPTR_WE && XPTR_SEL == 4'(p))
					ptr_reg[p] <= XPTR_WDATA;
				if (AGEN_REQ[0].en && AGEN_REQ[0].sel == 4'(p))
					ptr_reg[p] <= step_next[0];
				if (AGEN_REQ[1].en && AGEN_REQ[1].sel == 4'(p))
					ptr_reg[p] <= step_next[1];
				// Low-word ALU work runs beside stepping; it owns the low word.
				if (p < N_AUX && ALU_AR_WE && ALU_AR_SEL == 3'(p))
					ptr_reg[p].low <= ALU_AR_WDATA;
			end
		end
	end

	// Addresses issued to memory use the pointer before it steps.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			DATA_ADDR <= '0;
			COEF_ADDR <= '0;
		end
		else
		begin
			DATA_ADDR[0] <= ptr_reg[AGEN_REQ[0].sel];
			DATA_ADDR[1] <= ptr_reg[AGEN_REQ[1].sel];
			COEF_ADDR    <= ptr_reg[COEF_IX];
		end
	end

	// Mapped read decode; unmapped words read zero and drop the hit.
	always_comb
	begin
		rd_next  = WORD_RST;
		hit_next = 1'b0;
		for (int i = 0; i < N_ACC; i++)
		begin
			if (MMR_REQ.addr == MA_ACC_LOW[i])
			begin
				rd_next  = acc_reg[i].low;
				hit_next = 1'b1;
			end
			if (MMR_REQ.addr == MA_ACC_HIGH[i])
			begin
				rd_next  = acc_reg[i].high;
				hit_next = 1'b1;
			end
			if (MMR_REQ.addr == MA_ACC_GUARD[i])
			begin
				rd_next  = WORD_W'(acc_reg[i].guard);
				hit_next = 1'b1;
			end
		end
		for (int i = 0; i < N_TMP; i++)
		begin
			if (MMR_REQ.addr == MA_TMP[i])
			begin
				rd_next  = tmp_view(2'(i), LEGACY_COMPAT_FLAG, asm_view, tmp_reg);
				hit_next = 1'b1;
			end
		end
		for (int i = 0; i < N_PTR; i++)
		begin
			if (MMR_REQ.addr == MA_PTR_LOW[i])
			begin
				rd_next  = ptr_reg[i].low;
				hit_next = 1'b1;
			end
		end
		if (MMR_REQ.addr == MA_TRANSITION_REG_0)
		begin
			rd_next  = trn_reg[0];
			hit_next = 1'b1;
		end
		if (MMR_REQ.addr == MA_TRANSITION_REG_1)
		begin
			rd_next  = trn_reg[1];
			hit_next = 1'b1;
		end
		if (MMR_REQ.addr == MA_COEF_POINTER_PAGE)
		begin
			rd_next  = WORD_W'(ptr_reg[COEF_IX].page);
			hit_next = 1'b1;
		end
	end

	// Read data and hit are registered; hit follows any mapped access, read data only a read.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			MMR_RDATA <= WORD_RST;
			MMR_HIT   <= 1'b0;
		end
		else
		begin
			MMR_RDATA <= MMR_REQ.re ? rd_next : WORD_RST;
			MMR_HIT   <= (MMR_REQ.re || MMR_REQ.we) && hit_next;
		end
	end

	// Full-width register views for the execution units.
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			ACC_OUT <= '0;
			TRN_OUT <= '0;
			PTR_OUT <= '0;
		end
		else
		begin
			ACC_OUT <= acc_reg;
			TRN_OUT <= trn_reg;
			PTR_OUT <= ptr_reg;
		end
	end
endmodule
`default_nettype wire

/* design/dcr_pkg.sv */
/*
 * Shared constants and types for the CPU data register file.
 * Assumes one core clock and a synchronous active-high core reset.
 */
`default_nettype none
package dcr_pkg;
	localparam int ACC_W   = 40;
	localparam int WORD_W  = 16;
	localparam int GUARD_W = 8;
	localparam int PAGE_W  = 7;
	localparam int PTR_W   = 23;
	localparam int MA_W    = 7;
	localparam int ASM_W   = 5;
	localparam int N_ACC   = 4;
	localparam int N_TMP   = 4;
	localparam int N_AUX   = 8;
	localparam int N_PTR   = 9;
	localparam int COEF_IX = 8;

	// Memory-mapped word addresses of the register parts.
	localparam logic [MA_W-1:0] MA_ACC_LOW [N_ACC] = '{7'h08, 7'h0B, 7'h24, 7'h28};
	localparam logic [MA_W-1:0] MA_ACC_HIGH [N_ACC] = '{7'h09, 7'h0C, 7'h25, 7'h29};
	localparam logic [MA_W-1:0] MA_ACC_GUARD [N_ACC] = '{7'h0A, 7'h0D, 7'h26, 7'h2A};
	localparam logic [MA_W-1:0] MA_TMP [N_TMP] = '{7'h20, 7'h21, 7'h22, 7'h23};
	localparam logic [MA_W-1:0] MA_PTR_LOW [N_PTR] = '{7'h10, 7'h11, 7'h12, 7'h13,
		7'h14, 7'h15, 7'h16, 7'h17, 7'h27};
	localparam logic [MA_W-1:0] MA_TRANSITION_REG_0 = 7'h0E;
	localparam logic [MA_W-1:0] MA_TRANSITION_REG_1 = 7'h38;
	localparam logic [MA_W-1:0] MA_COEF_POINTER_PAGE = 7'h4F;

	// Reset values and the legacy temp register index.
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
	localparam logic [1:0]        TMP_ASM_IX = 2'h2;

	typedef struct packed {
		logic [GUARD_W-1:0] guard;
		logic [WORD_W-1:0]  high;
		logic [WORD_W-1:0]  low;
	} dcr_acc_t;

	typedef struct packed {
		logic [PAGE_W-1:0] page;
		logic [WORD_W-1:0] low;
	} dcr_xptr_t;

	typedef struct packed {
		logic              we;
		logic              re;
		logic [MA_W-1:0]   addr;
		logic [WORD_W-1:0] wdata;
	} dcr_mmr_req_t;

	typedef enum logic [2:0] {
		EXT_NONE   = 3'b001,
		EXT_DUAL16 = 3'b010,
		EXT_SINGLE = 3'b100
	} dcr_ext_op_t;

	typedef struct packed {
		dcr_ext_op_t op;
		logic        is_max;
		logic        trn_sel;
		logic [1:0]  src_a;
		logic [1:0]  src_b;
	} dcr_ext_req_t;

	typedef struct packed {
		logic              en;
		logic [3:0]        sel;
		logic [WORD_W-1:0] step;
		logic              wrap16;
	} dcr_agen_req_t;
endpackage
`default_nettype wire

/* design/dcr_addr_step.sv */
/*
 * Pointer step for the address generator: full 23-bit sum or 16-bit wrap.
 * Assumes the step is a signed 16-bit modifier supplied by the decoder.
 */
`timescale 1ns/1ps
`default_nettype none
module dcr_addr_step
	import dcr_pkg::*;
(
	input  wire dcr_xptr_t         ptr,
	input  wire logic [WORD_W-1:0] step,
	input  wire logic              wrap16,
	output dcr_xptr_t              next
);
	logic [PTR_W-1:0] sum23;
	logic [WORD_W-1:0] sum16;

	// The flat sum carries into the page; the wrapped sum never does.
	always_comb
	begin
		sum23 = PTR_W'(ptr) + PTR_W'($signed(step));
		sum16 = WORD_W'(ptr.low + step);
		if (wrap16)
			next = '{page: ptr.page, low: sum16};
		else
			next = dcr_xptr_t'(sum23);
	end
endmodule
`default_nettype wire

/* design/dcr_extremum.sv */
/*
 * Comparison of two accumulators for compare-and-select-extremum work.
 * A decision bit is 1 when operand b wins over operand a.
 */
`timescale 1ns/1ps
`default_nettype none
module dcr_extremum
	import dcr_pkg::*;
(
	input  wire dcr_acc_t a,
	input  wire dcr_acc_t b,
	input  wire logic     is_max,
	output logic          dec_high,
	output logic          dec_low,
	output logic          dec_full
);
	logic gt_high;
	logic gt_low;
	logic gt_full;

	// Signed compares per half and across the whole 40 bits.
	always_comb
	begin
		gt_high  = $signed(b.high) > $signed(a.high);
		gt_low   = $signed(b.low) > $signed(a.low);
		gt_full  = $signed(b) > $signed(a);
		dec_high = is_max ? gt_high : ($signed(b.high) < $signed(a.high));
		dec_low  = is_max ? gt_low : ($signed(b.low) < $signed(a.low));
		dec_full = is_max ? gt_full : ($signed(b) < $signed(a));
	end
endmodule
`default_nettype wire

/* test/dcr_dec_model.sv */
/*
 * Decoder-side model that issues mapped register requests.
 * Assumes the bench calls its tasks and that CLK runs free.
 */
`timescale 1ns/1ps
`default_nettype none
module dcr_dec_model
	import dcr_pkg::*;
(
	input  wire logic       CLK,
	output var dcr_mmr_req_t req
);
	// The bus starts idle.
	initial req = '0;

	// Raises one request at the falling edge and holds it over the taking edge.
	task automatic xfer(input logic we, input logic re, input logic [MA_W-1:0] a,
		input logic [WORD_W-1:0] d);
		@(negedge CLK);
		req = '{we: we, re: re, addr: a, wdata: d};
		@(posedge CLK);
	endtask

	// Releases the bus; leftovers are inverted so stale values are never reused.
	task automatic idle();
		@(negedge CLK);
		req = '{we: 1'b0, re: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
	endtask
endmodule
`default_nettype wire

/* test/dcr_regs_asserts.sv */
/*
 * Port checker for the CPU data register file.
 * Assumes it is bound to dcr_regs and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module dcr_regs_chk
	import dcr_pkg::*;
(
	input wire logic                    CLK,
	input wire logic                    RST,
	input wire logic                    LEGACY_COMPAT_FLAG,
	input wire dcr_mmr_req_t            MMR_REQ,
	input wire logic [WORD_W-1:0]       MMR_RDATA,
	input wire logic                    MMR_HIT,
	input wire logic                    ACC_WE,
	input wire logic                    SWAP_REQ,
	input wire logic [1:0]              SWAP_A,
	input wire logic [1:0]              SWAP_B,
	input wire logic                    SWAP_INVALID,
	input wire dcr_ext_req_t            EXT_REQ,
	input wire logic                    XPTR_WE,
	input wire logic                    ALU_AR_WE,
	input wire logic [2:0]              ALU_AR_SEL,
	input wire dcr_agen_req_t [1:0]     AGEN_REQ,
	input wire dcr_acc_t [N_ACC-1:0]    ACC_OUT,
	input wire logic [1:0][WORD_W-1:0]  TRN_OUT,
	input wire dcr_xptr_t [N_PTR-1:0]   PTR_OUT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic swap_ok;
	logic step0;

	// A legal swap pairing, and a lone unit step of one on pointer 0.
	assign swap_ok = (SWAP_A[0] == SWAP_B[0]) && (SWAP_A[1] != SWAP_B[1]);
	assign step0 = AGEN_REQ[0].en && AGEN_REQ[0].sel == 4'h0 && AGEN_REQ[0].step == 16'h0001
		&& !(AGEN_REQ[1].en && AGEN_REQ[1].sel == 4'h0) && !XPTR_WE && !MMR_REQ.we
		&& !(ALU_AR_WE && ALU_AR_SEL == 3'h0);

	a_rdata_idle: assert property (!MMR_REQ.re |=> MMR_RDATA == 16'h0000)
		else $error("read data not zero after an idle cycle");
	a_hit_transition_reg_1: assert property ((MMR_REQ.re || MMR_REQ.we) && MMR_REQ.addr == 7'h38 |=> MMR_HIT)
		else $error("transition register 1 address not answered");
	a_page_bits: assert property (MMR_REQ.re && MMR_REQ.addr == 7'h4F |=> MMR_RDATA[15:7] == 9'h000)
		else $error("coefficient page read shows unused bits");
	a_swap_flag: assert property (SWAP_REQ && !LEGACY_COMPAT_FLAG |=> SWAP_INVALID == !$past(swap_ok))
		else $error("swap refusal flag wrong");
	a_swap_move: assert property (SWAP_REQ && !LEGACY_COMPAT_FLAG && SWAP_A == 2'h0 && SWAP_B == 2'h2
		&& !ACC_WE && !MMR_REQ.we |=> ##1 ACC_OUT[0] == $past(ACC_OUT[2]) && ACC_OUT[2] == $past(ACC_OUT[0]))
		else $error("swap did not exchange the accumulators");
	a_trn_dual: assert property (EXT_REQ.op == EXT_DUAL16 |=> ##1 TRN_OUT[0][15:1] == $past(TRN_OUT[0][14:0])
		&& TRN_OUT[1][15:1] == $past(TRN_OUT[1][14:0]))
		else $error("dual select did not shift both transition registers");
	a_trn_single: assert property (EXT_REQ.op == EXT_SINGLE && EXT_REQ.trn_sel && !MMR_REQ.we
		|=> ##1 TRN_OUT[0] == $past(TRN_OUT[0]))
		else $error("single select touched the other transition register");
	a_page_carry: assert property (step0 && !AGEN_REQ[0].wrap16
		|=> ##1 PTR_OUT[0] == $past(PTR_OUT[0]) + 23'h000001)
		else $error("pointer step did not carry into the page");
	a_page_wrap: assert property (step0 && AGEN_REQ[0].wrap16
		|=> ##1 PTR_OUT[0] == {$past(PTR_OUT[0].page), $past(PTR_OUT[0].low) + 16'h0001})
		else $error("wrapped pointer step changed the page");

	c_swap_bad: cover property (SWAP_REQ && !swap_ok);
	c_dual: cover property (EXT_REQ.op == EXT_DUAL16);
	c_wrap: cover property (step0 && AGEN_REQ[0].wrap16);
endmodule

bind dcr_regs dcr_regs_chk i_dcr_regs_chk (.CLK(CLK), .RST(RST),
	.LEGACY_COMPAT_FLAG(LEGACY_COMPAT_FLAG), .MMR_REQ(MMR_REQ), .MMR_RDATA(MMR_RDATA),
	.MMR_HIT(MMR_HIT), .ACC_WE(ACC_WE), .SWAP_REQ(SWAP_REQ), .SWAP_A(SWAP_A), .SWAP_B(SWAP_B),
	.SWAP_INVALID(SWAP_INVALID), .EXT_REQ(EXT_REQ), .XPTR_WE(XPTR_WE), .ALU_AR_WE(ALU_AR_WE),
	.ALU_AR_SEL(ALU_AR_SEL), .AGEN_REQ(AGEN_REQ), .ACC_OUT(ACC_OUT), .TRN_OUT(TRN_OUT),
	.PTR_OUT(PTR_OUT));
`default_nettype wire

/* test/dcr_regs_tb.sv */
/*
 * Self-checking bench for the CPU data register file.
 * Assumes the decoder model and the checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
module dcr_regs_tb
	import dcr_pkg::*;
;
	logic CLK = 1'b0;
	logic RST = 1'b1;
	logic legacy = 1'b0, acc_we = 1'b0, swap_req = 1'b0, tmp_we = 1'b0, xptr_we = 1'b0;
	logic alu_we = 1'b0, pend = 1'b0, mmr_hit, swap_inv;
	logic [4:0] shift_mode = 5'h00;
	logic [1:0] acc_sel = 2'h0, swap_a = 2'h0, swap_b = 2'h0, tmp_sel = 2'h0;
	logic [1:0] mul_tsel = 2'h0, shift_tsel = 2'h0, metric_tsel = 2'h0;
	logic [2:0] alu_sel = 3'h0;
	logic [3:0] xptr_sel = 4'h0;
	logic [15:0] tmp_wdata = 16'h0000, alu_wdata = 16'h0000, mmr_rdata, mul_op, shift_cnt, metric;
	logic [39:0] acc_wdata = 40'h0000000000;
	logic [22:0] coef_addr;
	dcr_xptr_t xptr_wdata = '0;
	dcr_ext_req_t ext = '{EXT_NONE, 1'b0, 1'b0, 2'h0, 2'h0};
	dcr_agen_req_t [1:0] agen = '0;
	dcr_mmr_req_t mmr_req;
	logic [1:0][22:0] data_addr;
	dcr_acc_t [N_ACC-1:0] acc_out;
	logic [1:0][15:0] trn_out;
	dcr_xptr_t [N_PTR-1:0] ptr_out;
	dcr_acc_t accv [N_ACC];
	logic [16:0] exp_q [$];
	logic [31:0] seed = 32'h245FA00E;
	int miscompares = 0;
	int comparisons = 0;

	dcr_dec_model i_dcr_dec_model (.CLK(CLK), .req(mmr_req));
	dcr_regs i_dcr_regs (.CLK(CLK), .RST(RST), .LEGACY_COMPAT_FLAG(legacy),
		.SHIFT_MODE_FIELD(shift_mode), .MMR_REQ(mmr_req), .MMR_RDATA(mmr_rdata), .MMR_HIT(mmr_hit),
		.ACC_WE(acc_we), .ACC_SEL(acc_sel), .ACC_WDATA(acc_wdata), .SWAP_REQ(swap_req),
		.SWAP_A(swap_a), .SWAP_B(swap_b), .SWAP_INVALID(swap_inv), .EXT_REQ(ext), .TMP_WE(tmp_we),
		.TMP_SEL(tmp_sel), .TMP_WDATA(tmp_wdata), .MUL_TSEL(mul_tsel), .SHIFT_TSEL(shift_tsel),
		.METRIC_TSEL(metric_tsel), .MUL_OPERAND(mul_op), .SHIFT_COUNT(shift_cnt),
		.VITERBI_METRIC(metric), .XPTR_WE(xptr_we), .XPTR_SEL(xptr_sel), .XPTR_WDATA(xptr_wdata),
		.ALU_AR_WE(alu_we), .ALU_AR_SEL(alu_sel), .ALU_AR_WDATA(alu_wdata), .AGEN_REQ(agen),
		.DATA_ADDR(data_addr), .COEF_ADDR(coef_addr), .ACC_OUT(acc_out), .TRN_OUT(trn_out),
		.PTR_OUT(ptr_out));

	// Free-running core clock, 40 ns period.
	always #20 CLK = ~CLK;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Mapped accesses note their expected hit and read data first.
	task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic hit);
		exp_q.push_back({hit, 16'h0000});
		i_dcr_dec_model.xfer(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [6:0] a, input logic [16:0] e);
		exp_q.push_back(e);
		i_dcr_dec_model.xfer(1'b0, 1'b1, a, 16'h0000);
	endtask
	task automatic rel();
		i_dcr_dec_model.idle();
	endtask
	task automatic swap(input logic [1:0] a, input logic [1:0] b, input logic bad);
		@(negedge CLK);
		{swap_req, swap_a, swap_b} = {1'b1, a, b};
		@(negedge CLK);
		swap_req = 1'b0;
		check("swap refusal", {39'h0, bad}, {39'h0, swap_inv});
	endtask

	// Takes the oldest note whenever a mapped answer is due.
	always @(posedge CLK)
		pend <= mmr_req.we | mmr_req.re;
	always @(negedge CLK)
	begin
		if (pend)
			check("mapped answer", {23'h0, exp_q.pop_front()}, {23'h0, mmr_hit, mmr_rdata});
	end

	// Cuts a hang short.
	initial
	begin
		repeat (2000) @(posedge CLK);
		miscompares++;
		conclude();
	end

	// Main sequence.
	initial
	begin
		repeat (10) @(posedge CLK);
		@(negedge CLK);
		RST = 1'b0;
		rd(MA_TRANSITION_REG_1, 17'h10000);
		rd(MA_COEF_POINTER_PAGE, 17'h10000);
		rd(MA_TMP[3], 17'h10000);
		for (int i = 0; i < N_ACC; i++)
		begin
			seed = lfsr(seed);
			accv[i] = {seed[7:0], seed[31:16], seed[15:0]};
			wr(MA_ACC_LOW[i], seed[15:0], 1'b1);
			wr(MA_ACC_HIGH[i], seed[31:16], 1'b1);
			wr(MA_ACC_GUARD[i], seed[15:0], 1'b1);
			rd(MA_ACC_GUARD[i], {9'h100, seed[7:0]});
			rd(MA_ACC_HIGH[i], {1'b1, seed[31:16]});
			rd(MA_ACC_LOW[i], {1'b1, seed[15:0]});
		end
		wr(7'h2C, 16'hFFFF, 1'b0);
		rd(7'h2C, 17'h00000);
		wr(MA_COEF_POINTER_PAGE, 16'hFFFF, 1'b1);
		rd(MA_COEF_POINTER_PAGE, 17'h1007F);
		wr(MA_TRANSITION_REG_1, 16'hA5C3, 1'b1);
		rd(MA_TRANSITION_REG_1, 17'h1A5C3);
		wr(MA_TRANSITION_REG_0, 16'h0001, 1'b1);
		wr(MA_TRANSITION_REG_1, 16'h0000, 1'b1);
		rel();
		swap(2'h0, 2'h2, 1'b0);
		swap(2'h0, 2'h1, 1'b1);
		rd(MA_ACC_LOW[0], {1'b1, accv[2].low});
		rd(MA_ACC_HIGH[2], {1'b1, accv[0].high});
		rd(MA_ACC_LOW[1], {1'b1, accv[1].low});
		rel();
		// Extremum selects back to back: dual max, then single min into register 1.
		{acc_we, acc_sel, acc_wdata} = {1'b1, 2'h0, 40'h0000058000};
		@(negedge CLK);
		{acc_sel, acc_wdata} = {2'h2, 40'h0000030001};
		@(negedge CLK);
		acc_we = 1'b0;
		ext = '{EXT_DUAL16, 1'b1, 1'b0, 2'h0, 2'h2};
		@(negedge CLK);
		ext = '{EXT_SINGLE, 1'b0, 1'b1, 2'h0, 2'h2};
		@(negedge CLK);
		ext.op = EXT_NONE;
		rd(MA_TRANSITION_REG_0, 17'h10002);
		rd(MA_TRANSITION_REG_1, 17'h10003);
		rel();
		// Pointers: both lanes and the low-word ALU act in one cycle.
		{xptr_we, xptr_sel, xptr_wdata} = {1'b1, 4'h0, 23'h00FFFF};
		@(negedge CLK);
		{xptr_sel, xptr_wdata} = {4'h1, 23'h05FFFF};
		@(negedge CLK);
		{xptr_sel, xptr_wdata} = {4'h8, 23'h123456};
		@(negedge CLK);
		xptr_we = 1'b0;
		agen[0] = '{1'b1, 4'h0, 16'h0001, 1'b0};
		agen[1] = '{1'b1, 4'h1, 16'h0001, 1'b1};
		{alu_we, alu_sel, alu_wdata} = {1'b1, 3'h3, 16'hBEEF};
		@(negedge CLK);
		check("lane address", 40'h00FFFF, 40'(data_addr[0]));
		check("lane 1 address", 40'h05FFFF, 40'(data_addr[1]));
		agen = '0;
		alu_we = 1'b0;
		@(negedge CLK);
		check("pointer 0", 40'h010000, 40'(ptr_out[0]));
		check("pointer 1", 40'h050000, 40'(ptr_out[1]));
		check("coef address", 40'h123456, 40'(coef_addr));
		agen[0] = '{1'b1, 4'h0, 16'h0001, 1'b1};
		@(negedge CLK);
		agen = '0;
		rd(MA_PTR_LOW[3], 17'h1BEEF);
		rd(MA_PTR_LOW[0], 17'h10001);
		rd(MA_COEF_POINTER_PAGE, 17'h10012);
		rd(MA_PTR_LOW[8], 17'h13456);
		rel();
		// Temporary register feeds all three consumers.
		{tmp_we, tmp_sel, tmp_wdata} = {1'b1, 2'h1, 16'h1357};
		{mul_tsel, shift_tsel, metric_tsel} = 6'h15;
		@(negedge CLK);
		tmp_we = 1'b0;
		@(negedge CLK);
		check("multiplicand", 40'h1357, 40'(mul_op));
		check("shift count", 40'h1357, 40'(shift_cnt));
		check("metric", 40'h1357, 40'(metric));
		legacy = 1'b1;
		shift_mode = 5'h13;
		wr(MA_TMP[2], 16'h1111, 1'b1);
		rd(MA_TMP[2], 17'h1FFF3);
		rel();
		{acc_we, acc_sel, acc_wdata} = {1'b1, 2'h2, 40'h123456789A};
		@(negedge CLK);
		acc_we = 1'b0;
		rd(MA_ACC_LOW[0], 17'h1789A);
		rel();
		check("accumulator 0", 40'h123456789A, acc_out[0]);
		legacy = 1'b0;
		// A second reset in mid-run must clear what the scenarios left behind.
		RST = 1'b1;
		repeat (2) @(negedge CLK);
		RST = 1'b0;
		rd(MA_ACC_LOW[0], 17'h10000);
		rd(MA_PTR_LOW[3], 17'h10000);
		rel();
		check("accumulator 0 after reset", 40'h0, acc_out[0]);
		repeat (4) @(posedge CLK);
		conclude();
	end
endmodule
`default_nettype wire
